/* pkg/aes_pkg.sv */
`default_nettype none
package aes_pkg;
   // management frame fields
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [5:0] OP_LAST = 6'h01;
   localparam logic [5:0] ADR_LAST = 6'h09;
   localparam logic [5:0] TA_LAST = 6'h01;
   localparam logic [5:0] DAT_LAST = 6'h0f;
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam logic [5:0] CNT_ZERO = 6'h00;
   localparam logic [4:0] PHY_ADDR_DEF = 5'h01;
   // register offsets
   localparam logic [4:0] LPA_ADDR = 5'h05;
   localparam logic [4:0] EXP_ADDR = 5'h06;
   // expansion register layout
   localparam logic [15:0] EXP_RESET = 16'h0004;
   localparam int RSV_HI = 15;
   localparam int RSV_LO = 5;
   localparam int BIT_PDF = 4;
   localparam int BIT_LPNP = 3;
   localparam int BIT_NPA = 2;
   localparam int BIT_PGRX = 1;
   localparam int BIT_LPAN = 0;
   localparam logic [10:0] RSV_RESET = 11'h000;
   localparam logic [15:0] LPA_RESET = 16'h0000;
   localparam int LCW_NP_BIT = 15;
   localparam logic NPA_ABLE = 1'h1;
   // serial frame states
   typedef enum logic [6:0] {
      ST_PRE = 7'h01,
      ST_ST  = 7'h02,
      ST_OP  = 7'h04,
      ST_ADR = 7'h08,
      ST_TA  = 7'h10,
      ST_DAT = 7'h20,
      ST_RD  = 7'h40
   } aes_state_t;
endpackage
`default_nettype wire

/* pkg/aes_mgmt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface aes_mgmt_if;
   logic rd_stb;
   logic wr_stb;
   logic [4:0] reg_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   modport master (output rd_stb, output wr_stb, output reg_addr, output wr_data,
                   input rd_data);
   modport bank (input rd_stb, input wr_stb, input reg_addr, input wr_data,
                 output rd_data);
endinterface
`default_nettype wire

/* design/aes_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_pin_sync #(
   parameter int W = 2
) (
   input wire logic clk_sys, // system clock
   input wire logic reset, // sync reset, high
   input wire logic [W-1:0] pin_in, // asynchronous pins
   output logic [W-1:0] pin_sync // pins in clk_sys domain
);
   logic [W-1:0] meta;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               meta[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
            end else begin
               meta[i] <= pin_in[i];
               pin_sync[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* design/aes_status_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_status_bank (
   input wire logic clk_sys, // system clock
   input wire logic reset, // sync reset, high
   aes_mgmt_if.bank mgmt, // register access from the serial engine
   input wire logic cmd_override, // command override control bit
   input wire logic pd_fault_evt, // parallel detection fault pulse
   input wire logic lcw_stb, // link code word received pulse
   input wire logic [15:0] lcw_word, // received link code word
   input wire logic flp_ok_stb, // valid fast link pulse burst pulse
   input wire logic an_restart, // negotiation restart pulse
   output logic [15:0] lp_ability, // partner ability register
   output logic [10:0] aux_bits // override-writable reserved storage
);
   logic pd_fault;
   logic lp_np;
   logic page_rx;
   logic lp_an;
   logic exp_rd;
   assign exp_rd = mgmt.rd_stb && (mgmt.reg_addr == aes_pkg::EXP_ADDR);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         lp_ability <= aes_pkg::LPA_RESET;
      end else if (lcw_stb) begin
         lp_ability <= lcw_word;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         page_rx <= 1'b0;
      end else if (lcw_stb) begin
         page_rx <= 1'b1;
      end else if (exp_rd) begin
         page_rx <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pd_fault <= 1'b0;
      end else if (pd_fault_evt) begin
         pd_fault <= 1'b1;
      end else if (exp_rd) begin
         pd_fault <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         lp_np <= 1'b0;
      end else if (lcw_stb) begin
         lp_np <= lcw_word[aes_pkg::LCW_NP_BIT];
      end else if (an_restart) begin
         lp_np <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         lp_an <= 1'b0;
      end else if (flp_ok_stb) begin
         lp_an <= 1'b1;
      end else if (an_restart) begin
         lp_an <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aux_bits <= aes_pkg::RSV_RESET;
      end else if (mgmt.wr_stb && cmd_override && mgmt.reg_addr == aes_pkg::EXP_ADDR) begin
         aux_bits <= mgmt.wr_data[aes_pkg::RSV_HI:aes_pkg::RSV_LO];
      end
   end

   // snapshot taken before the read clear lands
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mgmt.rd_data <= aes_pkg::EXP_RESET;
      end else if (mgmt.rd_stb) begin
         case (mgmt.reg_addr)
            aes_pkg::EXP_ADDR: begin
               mgmt.rd_data <= '0;
               mgmt.rd_data[aes_pkg::RSV_HI:aes_pkg::RSV_LO] <= '0;
               mgmt.rd_data[aes_pkg::BIT_PDF] <= pd_fault;
               mgmt.rd_data[aes_pkg::BIT_LPNP] <= lp_np;
               mgmt.rd_data[aes_pkg::BIT_NPA] <= aes_pkg::NPA_ABLE;
               mgmt.rd_data[aes_pkg::BIT_PGRX] <= page_rx;
               mgmt.rd_data[aes_pkg::BIT_LPAN] <= lp_an;
            end
            aes_pkg::LPA_ADDR: begin
               mgmt.rd_data <= lp_ability;
            end
            default: begin
               mgmt.rd_data <= '0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* design/aes_top.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_top #(
   parameter logic [4:0] PHY_ADDR = aes_pkg::PHY_ADDR_DEF
) (
   input wire logic clk_sys, // 20 MHz system clock
   input wire logic reset, // sync reset, high
   input wire logic mdc, // management clock pin
   input wire logic mdio_in, // management data pin, input side
   output logic mdio_out, // management data pin, output value
   output logic mdio_oe, // management data pin, output enable
   input wire logic cmd_override, // command override control bit
   input wire logic pd_fault_evt, // parallel detection fault pulse
   input wire logic lcw_stb, // link code word received pulse
   input wire logic [15:0] lcw_word, // received link code word
   input wire logic flp_ok_stb, // valid burst received pulse
   input wire logic an_restart, // negotiation restart pulse
   output logic [15:0] lp_ability, // partner ability register
   output logic [10:0] aux_bits // reserved bit storage
);
   aes_mgmt_if mgmt ();

   logic [1:0] pins_sync;
   logic mdc_s;
   logic mdio_s;
   logic mdc_d;
   logic rise;
   aes_pkg::aes_state_t state;
   logic [5:0] ones_cnt;
   logic [5:0] bit_cnt;
   logic [1:0] op;
   logic [9:0] adr_sr;
   logic [15:0] dat_sr;
   logic [15:0] tx_sr;
   logic is_read;
   logic is_write;
   logic addr_hit;
   logic [4:0] phy_field;
   logic [4:0] reg_field;
   logic last_bit;
   logic rd_stb;
   logic wr_stb;
   logic [4:0] reg_addr;
   logic [15:0] wr_data;

   aes_pin_sync #(
      .W(2)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_in({mdc, mdio_in}),
      .pin_sync(pins_sync)
   );

   assign mdc_s = pins_sync[1];
   assign mdio_s = pins_sync[0];

   aes_status_bank u_bank (
      .clk_sys(clk_sys),
      .reset(reset),
      .mgmt(mgmt.bank),
      .cmd_override(cmd_override),
      .pd_fault_evt(pd_fault_evt),
      .lcw_stb(lcw_stb),
      .lcw_word(lcw_word),
      .flp_ok_stb(flp_ok_stb),
      .an_restart(an_restart),
      .lp_ability(lp_ability),
      .aux_bits(aux_bits)
   );

   assign mgmt.rd_stb = rd_stb;
   assign mgmt.wr_stb = wr_stb;
   assign mgmt.reg_addr = reg_addr;
   assign mgmt.wr_data = wr_data;

   // edge detect on the synchronised clock, never on the first flop
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mdc_d <= 1'b0;
      end else begin
         mdc_d <= mdc_s;
      end
   end

   assign rise = mdc_s && !mdc_d;

   // the final address bit is still on the pin at this edge
   assign phy_field = adr_sr[8:4];
   assign reg_field = {adr_sr[3:0], mdio_s};
   assign is_read = (op == aes_pkg::OP_READ);
   assign is_write = (op == aes_pkg::OP_WRITE);
   assign addr_hit = (phy_field == PHY_ADDR) &&
                     (reg_field == aes_pkg::EXP_ADDR || reg_field == aes_pkg::LPA_ADDR);
   assign last_bit = (bit_cnt == aes_pkg::DAT_LAST);

   // preamble: run of ones, saturating so long idle stays legal
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ones_cnt <= aes_pkg::CNT_ZERO;
      end else if (rise) begin
         if (!mdio_s) begin
            ones_cnt <= aes_pkg::CNT_ZERO;
         end else if (ones_cnt != aes_pkg::PRE_LEN) begin
            ones_cnt <= ones_cnt + aes_pkg::CNT_ONE;
         end
      end
   end

   // frame sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= aes_pkg::ST_PRE;
         bit_cnt <= aes_pkg::CNT_ZERO;
      end else if (rise) begin
         case (state)
            aes_pkg::ST_PRE: begin
               bit_cnt <= aes_pkg::CNT_ZERO;
               if (!mdio_s && ones_cnt == aes_pkg::PRE_LEN) begin
                  state <= aes_pkg::ST_ST;
               end
            end
            aes_pkg::ST_ST: begin
               bit_cnt <= aes_pkg::CNT_ZERO;
               if (mdio_s) begin
                  state <= aes_pkg::ST_OP;
               end else begin
                  state <= aes_pkg::ST_PRE;
               end
            end
            aes_pkg::ST_OP: begin
               if (bit_cnt == aes_pkg::OP_LAST) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  if (op[0] != mdio_s) begin
                     state <= aes_pkg::ST_ADR;
                  end else begin
                     state <= aes_pkg::ST_PRE;
                  end
               end else begin
                  bit_cnt <= bit_cnt + aes_pkg::CNT_ONE;
               end
            end
            aes_pkg::ST_ADR: begin
               if (bit_cnt == aes_pkg::ADR_LAST) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  // frames for other addresses are let pass untouched
                  if (addr_hit) begin
                     state <= aes_pkg::ST_TA;
                  end else begin
                     state <= aes_pkg::ST_PRE;
                  end
               end else begin
                  bit_cnt <= bit_cnt + aes_pkg::CNT_ONE;
               end
            end
            aes_pkg::ST_TA: begin
               if (is_read) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  state <= aes_pkg::ST_RD;
               end else if (bit_cnt == aes_pkg::TA_LAST) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  state <= aes_pkg::ST_DAT;
               end else begin
                  bit_cnt <= bit_cnt + aes_pkg::CNT_ONE;
               end
            end
            aes_pkg::ST_DAT: begin
               if (last_bit) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  state <= aes_pkg::ST_PRE;
               end else begin
                  bit_cnt <= bit_cnt + aes_pkg::CNT_ONE;
               end
            end
            aes_pkg::ST_RD: begin
               // one more edge past the last bit, to release the pin
               if (bit_cnt == aes_pkg::DAT_LAST + aes_pkg::CNT_ONE) begin
                  bit_cnt <= aes_pkg::CNT_ZERO;
                  state <= aes_pkg::ST_PRE;
               end else begin
                  bit_cnt <= bit_cnt + aes_pkg::CNT_ONE;
               end
            end
            default: begin
               bit_cnt <= aes_pkg::CNT_ZERO;
               state <= aes_pkg::ST_PRE;
            end
         endcase
      end
   end

   // opcode and address collection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         op <= 2'h0;
         adr_sr <= 10'h000;
      end else if (rise) begin
         if (state == aes_pkg::ST_OP) begin
            op <= {op[0], mdio_s};
         end
         if (state == aes_pkg::ST_ADR) begin
            adr_sr <= {adr_sr[8:0], mdio_s};
         end
      end
   end

   // write data collection
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dat_sr <= 16'h0000;
      end else if (rise && state == aes_pkg::ST_DAT) begin
         dat_sr <= {dat_sr[14:0], mdio_s};
      end
   end

   // register address held for the bank from the last address bit through the rest of the frame
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_addr <= 5'h00;
      end else if (rise && state == aes_pkg::ST_ADR && bit_cnt == aes_pkg::ADR_LAST) begin
         reg_addr <= reg_field;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_stb <= 1'b0;
      end else begin
         rd_stb <= rise && state == aes_pkg::ST_ADR && bit_cnt == aes_pkg::ADR_LAST &&
                   addr_hit && is_read;
      end
   end

   // write strobe carries data to the bank
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wr_stb <= 1'b0;
         wr_data <= 16'h0000;
      end else begin
         wr_stb <= rise && state == aes_pkg::ST_DAT && last_bit;
         if (rise && state == aes_pkg::ST_DAT && last_bit) begin
            wr_data <= {dat_sr[14:0], mdio_s};
         end
      end
   end

   // read data drive: zero for the second turnaround bit, then msb first
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mdio_oe <= 1'b0;
         mdio_out <= 1'b0;
         tx_sr <= 16'h0000;
      end else if (rise) begin
         if (state == aes_pkg::ST_TA && is_read) begin
            mdio_oe <= 1'b1;
            mdio_out <= 1'b0;
            tx_sr <= mgmt.rd_data;
         end else if (state == aes_pkg::ST_RD &&
                      bit_cnt != aes_pkg::DAT_LAST + aes_pkg::CNT_ONE) begin
            mdio_oe <= 1'b1;
            mdio_out <= tx_sr[15];
            tx_sr <= {tx_sr[14:0], 1'b0};
         end else begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* test/aes_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_top_assertions (
   input wire logic clk_sys, // system clock
   input wire logic reset, // sync reset, high
   input wire logic mdc, // management clock pin
   input wire logic mdio_out, // management data drive value
   input wire logic mdio_oe, // management data drive enable
   input wire logic cmd_override, // command override bit
   input wire logic lcw_stb, // link code word pulse
   input wire logic [15:0] lcw_word, // received link code word
   input wire logic [15:0] lp_ability, // partner ability register
   input wire logic [10:0] aux_bits // reserved bit storage
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // length of one read drive phase, seen in clk_sys cycles
   logic [8:0] oe_cnt;
   always_ff @(posedge clk_sys) begin
      if (reset || !mdio_oe)
         oe_cnt <= 9'h000;
      else
         oe_cnt <= oe_cnt + 9'h001;
   end

   property p_lp_load;
      lcw_stb |=> lp_ability == $past(lcw_word);
   endproperty
   a_lp_load: assert property (p_lp_load)
      else $error("partner ability not loaded from word");
   property p_lp_hold;
      !$stable(lp_ability) |-> $past(lcw_stb);
   endproperty
   a_lp_hold: assert property (p_lp_hold)
      else $error("partner ability changed without a word");
   property p_aux_gate;
      !$stable(aux_bits) |-> $past(cmd_override) || $past(cmd_override, 2);
   endproperty
   a_aux_gate: assert property (p_aux_gate)
      else $error("reserved storage changed without override");
   property p_aux_keep;
      (!cmd_override)[*3] |=> $stable(aux_bits);
   endproperty
   a_aux_keep: assert property (p_aux_keep)
      else $error("reserved storage moved while override low");
   property p_rst_clear;
      $fell(reset) |-> lp_ability == 16'h0000 && aux_bits == 11'h000 && !mdio_oe;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("state not cleared by reset");
   property p_ta_zero;
      $rose(mdio_oe) |-> $past(mdc, 2) && !mdio_out;
   endproperty
   a_ta_zero: assert property (p_ta_zero)
      else $error("read drive not started by clock rise with zero");
   property p_oe_len;
      $fell(mdio_oe) |-> oe_cnt >= 9'h0a9 && oe_cnt <= 9'h0ab;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read drive not seventeen clock periods long");
   property p_out_sync;
      mdio_oe && $changed(mdio_out) |-> $past(mdc, 2) && $past(mdc, 3);
   endproperty
   a_out_sync: assert property (p_out_sync)
      else $error("read data moved away from a clock rise");

   c_lcw: cover property (lcw_stb);
   c_read: cover property ($rose(mdio_oe));
   c_aux: cover property (!$stable(aux_bits));
endmodule
bind aes_top aes_top_assertions chk_u (
   .clk_sys(clk_sys),
   .reset(reset),
   .mdc(mdc),
   .mdio_out(mdio_out),
   .mdio_oe(mdio_oe),
   .cmd_override(cmd_override),
   .lcw_stb(lcw_stb),
   .lcw_word(lcw_word),
   .lp_ability(lp_ability),
   .aux_bits(aux_bits)
);
`default_nettype wire

/* test/aes_sta_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_sta_model #(
   parameter logic [4:0] PHY_ADDR = aes_pkg::PHY_ADDR_DEF
) (
   input wire logic clk_sys, // system clock, driven on falling edge
   input wire logic mdio_line, // resolved data line, pulled up
   output logic mdc, // management clock, still between frames
   output logic mdio_en, // high while this side drives the line
   output logic mdio_bit // value driven while enabled
);
   initial begin
      mdc = 1'b0;
      mdio_en = 1'b0;
      mdio_bit = 1'b1;
   end

   // ten clk_sys per bit keeps both clock phases well above the minimum
   task automatic clk_bit(input logic b, output logic s);
      mdio_bit = b;
      repeat (5) @(negedge clk_sys);
      s = mdio_line;
      mdc = 1'b1;
      repeat (5) @(negedge clk_sys);
      mdc = 1'b0;
   endtask

   // raw lets a scenario put ones into reserved bits on purpose
   task automatic xfer(input logic wr, input logic raw, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      logic [15:0] d;
      logic s;
      d = wd;
      if (!raw)
         d[15:5] = aes_pkg::RSV_RESET;
      f = {32'hffff_ffff, 2'b01, wr ? aes_pkg::OP_WRITE : aes_pkg::OP_READ,
           PHY_ADDR, ra, 2'b10, d};
      mdio_en = 1'b1;
      for (int i = 63; i >= 0; i--) begin
         if (!wr && i == 17)
            mdio_en = 1'b0;
         clk_bit(f[i], s);
         rd = {rd[14:0], s};
      end
      mdio_en = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("mismatch %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb;
   localparam logic [4:0] EA = aes_pkg::EXP_ADDR;
   localparam logic [4:0] LA = aes_pkg::LPA_ADDR;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic ovr = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [15:0] word = 16'h0000;
   logic mdc, sta_en, sta_bit, dut_out, dut_oe;
   logic [15:0] lp_ability;
   logic [10:0] aux_bits;
   logic [15:0] rd_val;
   int n_fail = 0;
   int compares = 0;
   // line is pulled up when nobody drives it
   wire logic mdio_line = dut_oe ? dut_out : (sta_en ? sta_bit : 1'b1);

   always #25 clk_sys = ~clk_sys;

   aes_top dut_u (
      .clk_sys(clk_sys),
      .reset(reset),
      .mdc(mdc),
      .mdio_in(mdio_line),
      .mdio_out(dut_out),
      .mdio_oe(dut_oe),
      .cmd_override(ovr),
      .pd_fault_evt(ev[1]),
      .lcw_stb(ev[0]),
      .lcw_word(word),
      .flp_ok_stb(ev[2]),
      .an_restart(ev[3]),
      .lp_ability(lp_ability),
      .aux_bits(aux_bits)
   );

   aes_sta_model sta_u (
      .clk_sys(clk_sys),
      .mdio_line(mdio_line),
      .mdc(mdc),
      .mdio_en(sta_en),
      .mdio_bit(sta_bit)
   );

   task automatic summarize();
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
      sta_u.xfer(1'b0, 1'b0, a, 16'h0000, rd_val);
      `CHK(nm, exp, rd_val)
   endtask

   task automatic wr(input logic raw, input logic [15:0] d);
      sta_u.xfer(1'b1, raw, EA, d, rd_val);
   endtask

   // ev: 0 word, 1 fault, 2 burst, 3 restart
   task automatic pulse(input logic [3:0] k, input logic [15:0] w);
      @(negedge clk_sys);
      ev = k;
      word = w;
      @(negedge clk_sys);
      ev = 4'h0;
      repeat (3) @(negedge clk_sys);
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys);
      n_fail++;
      summarize();
   end

   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      rd(EA, aes_pkg::EXP_RESET, "exp_after_reset");
      rd(LA, aes_pkg::LPA_RESET, "lpa_after_reset");
      pulse(4'h4, 16'h0000);
      rd(EA, 16'h0005, "exp_burst_seen");
      pulse(4'h1, 16'h81e1);
      `CHK("lp_ability_port", 16'h81e1, lp_ability)
      rd(LA, 16'h81e1, "lpa_loaded");
      rd(EA, 16'h000f, "exp_page_np");
      rd(EA, 16'h000d, "exp_page_cleared");
      // fault pulse long gone before the read
      pulse(4'h2, 16'h0000);
      repeat (50) @(negedge clk_sys);
      rd(EA, 16'h001d, "exp_fault_latched");
      rd(EA, 16'h000d, "exp_fault_cleared");
      pulse(4'h1, 16'h01e1);
      // unmapped register: line stays at its pull-up and page received survives
      rd(5'h07, 16'hffff, "other_reg_undriven");
      rd(EA, 16'h0007, "exp_page_no_np");
      ovr = 1'b0;
      wr(1'b1, 16'hffff);
      `CHK("aux_locked", 11'h000, aux_bits)
      rd(EA, 16'h0005, "exp_low_bits_kept");
      ovr = 1'b1;
      wr(1'b1, 16'ha5e0);
      `CHK("aux_written", 11'h52f, aux_bits)
      rd(EA, 16'h0005, "exp_rsv_zero");
      wr(1'b0, 16'hffff);
      `CHK("aux_default", 11'h000, aux_bits)
      ovr = 1'b0;
      pulse(4'h8, 16'h0000);
      rd(EA, aes_pkg::EXP_RESET, "exp_after_restart");
      summarize();
   end
endmodule
`default_nettype wire
